// file: design/osb_pkg.sv
// Package for the output setpoint command bank: command codes, page codes,
// reset values and timing. Assumes a 40 MHz clock and a byte-level command port.
package osb_pkg;
	localparam logic [7:0] CMD_PAGE = 8'h00;
	localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
	localparam logic [7:0] CMD_FORMAT_REPORT = 8'h20;
	localparam logic [7:0] CMD_TARGET_SETPOINT = 8'h21;
	localparam logic [7:0] CMD_FACTORY_TRIM = 8'h22;
	localparam logic [7:0] CMD_CAL_OFFSET = 8'h23;
	localparam logic [7:0] CMD_UPPER_LIMIT = 8'h24;
	localparam logic [7:0] PAGE_CH0 = 8'h00;
	localparam logic [7:0] PAGE_CH1 = 8'h01;
	localparam logic [7:0] PAGE_BOTH = 8'hff;
	// Linear mode, exponent -13 in bits 4:0
	localparam logic [7:0] FORMAT_REPORT_VALUE = 8'h13;
	localparam logic [15:0] ZERO_WORD = 16'h0000;
	// Limit reset is 1.15 x strap: num/den applied to the strap word
	localparam int LIMIT_NUM = 115;
	localparam int LIMIT_DEN = 100;
	// Highest programmable limit, 5.5 V * 2^13 = 45056
	localparam logic [15:0] LIMIT_CEIL = 16'hb000;
	localparam int CLOCK_HZ = 40_000_000;
	localparam int RESTORE_MS = 100;
	localparam int RESTORE_CYCLES = CLOCK_HZ / 1000 * RESTORE_MS;
	localparam int NUM_CH = 2;
	typedef enum logic [1:0] {
		OSB_IDLE = 2'b00,
		OSB_LOAD = 2'b01,
		OSB_BUSY = 2'b10
	} osb_state_t;
endpackage

// file: design/osb_user_store.sv
`timescale 1ns/1ps
// Nonvolatile user store image for both channels.
// Assumes the store contents are presented as parameters (no write path here).
module osb_user_store #(
	parameter logic [15:0] USER_TRIM = 16'h0000,
	parameter logic [15:0] USER_OFFSET = 16'h0000
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [0:0] sel,
	output logic [15:0] trim_ff,
	output logic [15:0] offset_ff
);
	// Registered read so the restore sees stable data one cycle later
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			trim_ff <= 16'h0000;
			offset_ff <= 16'h0000;
		end else begin
			trim_ff <= sel[0] ? USER_TRIM : USER_TRIM;
			offset_ff <= USER_OFFSET;
		end
	end
endmodule

// file: design/osb_clamp.sv
`timescale 1ns/1ps
// Effective setpoint arithmetic for one channel: target + trim + offset, clamped.
// Pure combinational; the caller registers the result.
module osb_clamp (
	input wire logic [15:0] target,
	input wire logic [15:0] trim,
	input wire logic [15:0] offset,
	input wire logic [15:0] limit,
	output logic [15:0] result
);
	logic signed [18:0] sum;
	always_comb begin
		sum = $signed({3'b000, target}) + $signed({{3{trim[15]}}, trim})
			+ $signed({{3{offset[15]}}, offset});
		if (sum < 0) begin
			result = 16'h0000;
		end else if (sum > $signed({3'b000, limit})) begin
			result = limit;
		end else begin
			result = sum[15:0];
		end
	end
endmodule

// file: design/osb_bank.sv
`timescale 1ns/1ps
// Command-register bank for two output channels, reached by a byte command port.
// Assumes an upstream PMBus engine presents one decoded command at a time:
// cmd_valid with cmd_code and a 16-bit word; reads return on rd_data next cycle.
// Function
// - Restore command and power-up reload user store
// - Security level becomes 1 after restore
// - Ignore bus for 100ms during restore
// - Format report reads fixed 13h
// - Bits 4:0 carry exponent minus thirteen
// - Paged unsigned 16-bit target setpoint
// - Target capped at 115% strap or limit
// - Target resets to strap voltage
// - Paged signed trim, resets zero
// - Paged signed calibration offset, resets zero
// - Output setpoint clamped to upper limit
// - Limit not rescaled by target change
// - Limit resets 1.15 strap, max 5.5V
// - Two-byte per-page registers, global restore
// - Page 00h,01h,FFh select channels
module osb_bank #(
	parameter int RESTORE_CYCLES = osb_pkg::RESTORE_CYCLES,
	parameter logic [15:0] USER_TRIM = 16'h0000,
	parameter logic [15:0] USER_OFFSET = 16'h0000
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [15:0] strap_voltage_select,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	output logic cmd_ack,
	output logic [15:0] rd_data_ff,
	output logic busy,
	output logic [1:0] security_level_ff,
	output logic [15:0] setpoint0_ff,
	output logic [15:0] setpoint1_ff
);
	osb_pkg::osb_state_t state_ff;
	logic [31:0] count_ff;
	logic [7:0] page_ff;
	logic [15:0] target_ff [osb_pkg::NUM_CH];
	logic [15:0] trim_ff [osb_pkg::NUM_CH];
	logic [15:0] offset_ff [osb_pkg::NUM_CH];
	logic [15:0] limit_ff [osb_pkg::NUM_CH];
	logic [15:0] eff [osb_pkg::NUM_CH];
	logic [15:0] store_trim;
	logic [15:0] store_offset;
	logic [31:0] strap_limit;
	logic [15:0] limit_reset;
	logic [15:0] target_bound;
	logic [15:0] target_wr;
	logic take;
	logic start_restore;
	logic init_done_ff;
	logic [0:0] rd_ch;

	// 1.15 x strap, saturated to the programmable ceiling
	assign strap_limit = 32'(strap_voltage_select) * 32'(osb_pkg::LIMIT_NUM)
		/ 32'(osb_pkg::LIMIT_DEN);
	assign limit_reset = (strap_limit > 32'(osb_pkg::LIMIT_CEIL)) ? osb_pkg::LIMIT_CEIL
		: strap_limit[15:0];

	// Bus is deaf while a restore runs; requests are dropped, not queued
	assign busy = (state_ff != osb_pkg::OSB_IDLE);
	assign take = cmd_valid && !busy;
	assign cmd_ack = take;
	assign start_restore = take && cmd_write && cmd_code == osb_pkg::CMD_RESTORE_USER;
	assign rd_ch = (page_ff == osb_pkg::PAGE_BOTH) ? 1'b0 : page_ff[0];

	// Bound for target writes uses channel of the current page (ch0 for both)
	always_comb begin
		target_bound = (limit_ff[rd_ch] > limit_reset) ? limit_ff[rd_ch] : limit_reset;
		target_wr = (cmd_wdata > target_bound) ? target_bound : cmd_wdata;
	end

	osb_user_store #(
		.USER_TRIM(USER_TRIM),
		.USER_OFFSET(USER_OFFSET)
	) u_store (
		.clock(clock),
		.resetn(resetn),
		.sel(rd_ch),
		.trim_ff(store_trim),
		.offset_ff(store_offset)
	);

	// Restore sequencer: power-up load, then 100 ms quiet time
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_ff <= osb_pkg::OSB_LOAD;
			count_ff <= 32'h0000_0000;
		end else begin
			unique case (state_ff)
				osb_pkg::OSB_IDLE: begin
					if (start_restore) begin
						state_ff <= osb_pkg::OSB_LOAD;
					end
				end
				osb_pkg::OSB_LOAD: begin
					state_ff <= osb_pkg::OSB_BUSY;
					count_ff <= 32'h0000_0000;
				end
				osb_pkg::OSB_BUSY: begin
					if (count_ff >= 32'(RESTORE_CYCLES - 1)) begin
						state_ff <= osb_pkg::OSB_IDLE;
					end else begin
						count_ff <= count_ff + 32'h0000_0001;
					end
				end
				default: state_ff <= osb_pkg::OSB_IDLE;
			endcase
		end
	end

	// Security level is forced to 1 in the load state, one cycle before the reload lands
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			security_level_ff <= 2'h0;
		end else if (state_ff == osb_pkg::OSB_LOAD) begin
			security_level_ff <= 2'h1;
		end
	end

	// Page selector; unknown page codes are ignored
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			page_ff <= osb_pkg::PAGE_CH0;
		end else if (take && cmd_write && cmd_code == osb_pkg::CMD_PAGE) begin
			if (cmd_wdata[7:0] == osb_pkg::PAGE_CH0 || cmd_wdata[7:0] == osb_pkg::PAGE_CH1
				|| cmd_wdata[7:0] == osb_pkg::PAGE_BOTH) begin
				page_ff <= cmd_wdata[7:0];
			end
		end
	end

	// Strap is sampled on the first clock after reset release, not under reset
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			init_done_ff <= 1'b0;
		end else begin
			init_done_ff <= 1'b1;
		end
	end

	// Per-channel paged registers, one generate copy per channel
	for (genvar ch = 0; ch < osb_pkg::NUM_CH; ch++) begin : g_ch
		logic sel_ch;
		assign sel_ch = (page_ff == osb_pkg::PAGE_BOTH) || (page_ff[0] == 1'(ch));
		always_ff @(posedge clock or negedge resetn) begin
			if (!resetn) begin
				target_ff[ch] <= osb_pkg::ZERO_WORD;
				limit_ff[ch] <= osb_pkg::ZERO_WORD;
				trim_ff[ch] <= osb_pkg::ZERO_WORD;
				offset_ff[ch] <= osb_pkg::ZERO_WORD;
			end else if (!init_done_ff) begin
				target_ff[ch] <= strap_voltage_select;
				limit_ff[ch] <= limit_reset;
			end else if (state_ff == osb_pkg::OSB_BUSY && count_ff == 32'h0000_0000) begin
				trim_ff[ch] <= store_trim;
				offset_ff[ch] <= store_offset;
			end else if (take && cmd_write && sel_ch) begin
				unique case (cmd_code)
					osb_pkg::CMD_TARGET_SETPOINT: target_ff[ch] <= target_wr;
					osb_pkg::CMD_FACTORY_TRIM: trim_ff[ch] <= cmd_wdata;
					osb_pkg::CMD_CAL_OFFSET: offset_ff[ch] <= cmd_wdata;
					osb_pkg::CMD_UPPER_LIMIT: begin
						// Limit stands alone; target edits never touch it
						limit_ff[ch] <= (cmd_wdata > osb_pkg::LIMIT_CEIL) ? osb_pkg::LIMIT_CEIL
							: cmd_wdata;
					end
					default: ;
				endcase
			end
		end
		osb_clamp u_clamp (
			.target(target_ff[ch]),
			.trim(trim_ff[ch]),
			.offset(offset_ff[ch]),
			.limit(limit_ff[ch]),
			.result(eff[ch])
		);
	end

	// Effective setpoints registered toward the regulation loop
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			setpoint0_ff <= osb_pkg::ZERO_WORD;
			setpoint1_ff <= osb_pkg::ZERO_WORD;
		end else begin
			setpoint0_ff <= eff[0];
			setpoint1_ff <= eff[1];
		end
	end

	// Read data; for page both, channel 0 answers
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rd_data_ff <= osb_pkg::ZERO_WORD;
		end else if (take && !cmd_write) begin
			unique case (cmd_code)
				osb_pkg::CMD_PAGE: rd_data_ff <= {8'h00, page_ff};
				osb_pkg::CMD_FORMAT_REPORT:
					rd_data_ff <= {8'h00, osb_pkg::FORMAT_REPORT_VALUE};
				osb_pkg::CMD_TARGET_SETPOINT: rd_data_ff <= target_ff[rd_ch];
				osb_pkg::CMD_FACTORY_TRIM: rd_data_ff <= trim_ff[rd_ch];
				osb_pkg::CMD_CAL_OFFSET: rd_data_ff <= offset_ff[rd_ch];
				osb_pkg::CMD_UPPER_LIMIT: rd_data_ff <= limit_ff[rd_ch];
				default: rd_data_ff <= osb_pkg::ZERO_WORD;
			endcase
		end
	end

	// Checks
	property p_restore_busy;
		@(posedge clock) disable iff (!resetn)
		start_restore |=> ##1 busy [*8];
	endproperty
	a_restore_busy: assert property (p_restore_busy) else $error("restore not busy");

	property p_sec_level;
		@(posedge clock) disable iff (!resetn)
		(state_ff == osb_pkg::OSB_LOAD) |=> (security_level_ff == 2'h1);
	endproperty
	a_sec_level: assert property (p_sec_level) else $error("security level not 1");

	property p_no_ack_busy;
		@(posedge clock) disable iff (!resetn)
		busy |=> $stable(page_ff) && $stable(rd_data_ff);
	endproperty
	a_no_ack_busy: assert property (p_no_ack_busy) else $error("bank answered while busy");

	property p_format;
		@(posedge clock) disable iff (!resetn)
		(take && !cmd_write && cmd_code == osb_pkg::CMD_FORMAT_REPORT)
			|=> (rd_data_ff == 16'h0013);
	endproperty
	a_format: assert property (p_format) else $error("format report wrong");

	property p_clamp0;
		@(posedge clock) disable iff (!resetn)
		##1 setpoint0_ff <= $past(limit_ff[0]);
	endproperty
	a_clamp0: assert property (p_clamp0) else $error("setpoint above limit");

	property p_target_bound;
		@(posedge clock) disable iff (!resetn)
		(take && cmd_write && cmd_code == osb_pkg::CMD_TARGET_SETPOINT && page_ff == 8'h00)
			|=> (target_ff[0] <= $past(target_bound));
	endproperty
	a_target_bound: assert property (p_target_bound) else $error("target over bound");

	property p_limit_kept;
		@(posedge clock) disable iff (!resetn)
		(init_done_ff && take && cmd_write && cmd_code == osb_pkg::CMD_TARGET_SETPOINT)
			|=> $stable(limit_ff[0]) && $stable(limit_ff[1]);
	endproperty
	a_limit_kept: assert property (p_limit_kept) else $error("limit rescaled");

	property p_page1_only;
		@(posedge clock) disable iff (!resetn)
		(init_done_ff && take && cmd_write && page_ff == osb_pkg::PAGE_CH1
			&& cmd_code == osb_pkg::CMD_FACTORY_TRIM) |=> $stable(trim_ff[0]);
	endproperty
	a_page1_only: assert property (p_page1_only) else $error("page 1 wrote ch0");

	property p_clamp1;
		@(posedge clock) disable iff (!resetn)
		##1 setpoint1_ff <= $past(limit_ff[1]);
	endproperty
	a_clamp1: assert property (p_clamp1) else $error("setpoint 1 above limit");

	// Page both answers reads from channel 0 so a read has one defined source
	property p_rd_both;
		@(posedge clock) disable iff (!resetn)
		(take && !cmd_write && cmd_code == osb_pkg::CMD_TARGET_SETPOINT
			&& page_ff == osb_pkg::PAGE_BOTH) |=> (rd_data_ff == $past(target_ff[0]));
	endproperty
	a_rd_both: assert property (p_rd_both) else $error("page both read not ch0");

	property p_restore_load;
		@(posedge clock) disable iff (!resetn)
		(init_done_ff && state_ff == osb_pkg::OSB_BUSY && count_ff == 32'h0000_0000)
			|=> (trim_ff[0] == $past(store_trim)) && (offset_ff[1] == $past(store_offset));
	endproperty
	a_restore_load: assert property (p_restore_load) else $error("reload missed");

	property p_limit_ceil;
		@(posedge clock) disable iff (!resetn)
		(limit_ff[0] <= osb_pkg::LIMIT_CEIL) && (limit_ff[1] <= osb_pkg::LIMIT_CEIL);
	endproperty
	a_limit_ceil: assert property (p_limit_ceil) else $error("limit above ceiling");

	// The counter stands in for a long repetition, which the tools could not unroll
	property p_quiet_len;
		@(posedge clock) disable iff (!resetn)
		(state_ff == osb_pkg::OSB_BUSY && count_ff < 32'(RESTORE_CYCLES - 1)) |=> busy;
	endproperty
	a_quiet_len: assert property (p_quiet_len) else $error("quiet time cut short");

	c_restore: cover property (@(posedge clock) disable iff (!resetn) start_restore);
	c_both: cover property (@(posedge clock) disable iff (!resetn)
		page_ff == osb_pkg::PAGE_BOTH && take && cmd_write);
	c_clamped: cover property (@(posedge clock) disable iff (!resetn)
		eff[0] == limit_ff[0] && init_done_ff);
	c_quiet_end: cover property (@(posedge clock) disable iff (!resetn) $fell(busy));
endmodule

// file: verif/osb_host.sv
`timescale 1ns/1ps
// Host model: one decoded command at a time to the bank.
// Assumes the bank acks in the taking cycle and answers reads one edge later.
module osb_host (
	input wire logic clock,
	input wire logic cmd_ack,
	input wire logic [15:0] rd_data_ff,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata
);
	// Idle lines at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h5a;
		cmd_wdata = 16'ha5a5;
	end
	// Held from a falling edge until acked; released on the next falling edge
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
		output logic [15:0] rd, output bit ok);
		int n;
		ok = 1'b0;
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_code = code;
		cmd_wdata = wd; // Page word carries only legal selector codes
		for (n = 0; n < 200 && !ok; n++) begin
			@(posedge clock);
			ok = (cmd_ack === 1'b1);
		end
		@(negedge clock);
		rd = rd_data_ff;
		// Released lines flip so a stale value cannot pass for a fresh one
		cmd_valid = 1'b0;
		cmd_write = ~wr;
		cmd_code = ~code;
		cmd_wdata = ~wd;
	endtask
endmodule

// file: verif/osb_bank_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the setpoint bank, driven through the host model.
// Assumes a shortened restore time and a fixed store image.
module osb_bank_tb;
	localparam int RC = 20;
	localparam logic [15:0] STRAP = 16'h2800;
	localparam logic [15:0] LIM0 = 16'h2e00; // 1.15 x strap, exact
	localparam logic [15:0] UTRIM = 16'h0010;
	localparam logic [15:0] UOFF = 16'h0008;
	localparam logic [7:0] TGT = osb_pkg::CMD_TARGET_SETPOINT;
	localparam logic [7:0] LIM = osb_pkg::CMD_UPPER_LIMIT;
	localparam logic [7:0] PG = osb_pkg::CMD_PAGE;
	localparam logic [7:0] FMT = osb_pkg::CMD_FORMAT_REPORT;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic cmd_valid, cmd_write, cmd_ack, busy;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata, rd_data_ff, sp0, sp1;
	logic [1:0] sec;
	int n_errors = 0;
	int checks_done = 0;
	// 40 MHz clock
	always #12.5 clock = ~clock;
	osb_bank #(.RESTORE_CYCLES(RC), .USER_TRIM(UTRIM), .USER_OFFSET(UOFF)) dut (
		.clock(clock), .resetn(resetn), .strap_voltage_select(STRAP),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack), .rd_data_ff(rd_data_ff),
		.busy(busy), .security_level_ff(sec), .setpoint0_ff(sp0), .setpoint1_ff(sp1));
	osb_host host (.clock(clock), .cmd_ack(cmd_ack), .rd_data_ff(rd_data_ff),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata));
	// Single comparison for every 16-bit result
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic test_done();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// A missing ack means a hang, so the run is closed at once
	task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd,
		output logic [15:0] rd);
		bit ok;
		host.xfer(wr, code, wd, rd, ok);
		if (!ok) begin
			n_errors++;
			$display("CHECK FAILED %0t no ack", $time);
			test_done();
		end
	endtask
	task automatic wr(input logic [7:0] code, input logic [15:0] wd);
		logic [15:0] d;
		cmd(1'b1, code, wd, d);
	endtask
	task automatic rdc(input logic [7:0] code, input logic [15:0] exp);
		logic [15:0] d;
		cmd(1'b0, code, 16'h0000, d);
		chk16(d, exp, "read");
	endtask
	// Setpoints lag a write by one edge
	task automatic settle();
		repeat (3) @(negedge clock);
	endtask
	// Bounded wait for the quiet time to end; a stuck bank closes the run
	task automatic wait_idle(output int n);
		for (n = 0; n < 100 && busy !== 1'b0; n++)
			@(negedge clock);
		if (busy !== 1'b0) begin
			n_errors++;
			$display("CHECK FAILED %0t busy stuck", $time);
			test_done();
		end
	endtask
	task automatic t_powerup();
		int n;
		wait_idle(n);
		chk16({14'h0000, sec}, 16'h0001, "security");
		rdc(FMT, 16'h0013);
		rdc(TGT, STRAP);
		rdc(LIM, LIM0);
		rdc(osb_pkg::CMD_FACTORY_TRIM, UTRIM);
		rdc(osb_pkg::CMD_CAL_OFFSET, UOFF);
		chk16(sp1, STRAP + UTRIM + UOFF, "sum");
	endtask
	task automatic t_pages();
		wr(PG, {8'h00, osb_pkg::PAGE_CH1});
		wr(TGT, 16'h2000);
		settle();
		chk16(sp1, 16'h2018, "ch1");
		chk16(sp0, STRAP + 16'h0018, "ch0");
		wr(PG, {8'h00, osb_pkg::PAGE_BOTH});
		wr(osb_pkg::CMD_CAL_OFFSET, 16'hfff8);
		wr(osb_pkg::CMD_FACTORY_TRIM, 16'h0000);
		settle();
		chk16(sp0, STRAP - 16'h0008, "ch0 neg");
		chk16(sp1, 16'h1ff8, "ch1 neg");
		rdc(TGT, STRAP);
	endtask
	// Limit below the strap bound, then above it
	task automatic t_clamp();
		wr(PG, {8'h00, osb_pkg::PAGE_CH0});
		wr(LIM, 16'h2100);
		wr(TGT, 16'h2400);
		settle();
		chk16(sp0, 16'h2100, "clamp");
		rdc(LIM, 16'h2100);
		wr(TGT, 16'h3000);
		rdc(TGT, LIM0);
		wr(LIM, 16'hffff);
		rdc(LIM, 16'hb000);
		wr(TGT, 16'h3000);
		rdc(TGT, 16'h3000);
		wr(FMT, 16'h0055);
		rdc(FMT, 16'h0013);
	endtask
	task automatic t_restore();
		int n;
		wr(osb_pkg::CMD_FACTORY_TRIM, 16'h0100);
		wr(osb_pkg::CMD_RESTORE_USER, 16'h0000);
		wait_idle(n);
		chk16(16'(n >= RC && n <= RC + 3), 16'h0001, "quiet");
		chk16({14'h0000, sec}, 16'h0001, "security");
		rdc(osb_pkg::CMD_FACTORY_TRIM, UTRIM);
		wr(PG, {8'h00, osb_pkg::PAGE_CH1});
		rdc(osb_pkg::CMD_CAL_OFFSET, UOFF);
	endtask
	// Reset for four cycles, then the scenarios in turn
	initial begin
		repeat (4) @(negedge clock);
		resetn = 1'b1;
		t_powerup();
		t_pages();
		t_clamp();
		t_restore();
		test_done();
	end
endmodule
